// >>> core/sswd_consts.vh
// Purpose: constants for the supply supervisor and watchdog
// Assumes: core_clk at 100 MHz
// Notes: times kept in their own unit, cycle counts derived
`ifndef SSWD_CONSTS_VH
`define SSWD_CONSTS_VH
`define SSWD_CLK_MHZ 100
`define SSWD_RESET_MS 200
`define SSWD_BROWN_MS 140
`define SSWD_WD_MS 1600
`define SSWD_KICK_NS 50
`define SSWD_CLK_NS 10
// cycle counts at counter width: ms * 1000 * MHz, all exact here
`define SSWD_RESET_CYC 28'h1312D00
`define SSWD_BROWN_CYC 28'h0D59F80
`define SSWD_WD_CYC 28'h9896800
`define SSWD_KICK_CYC ((`SSWD_KICK_NS + `SSWD_CLK_NS - 1) / `SSWD_CLK_NS)
`define SSWD_CNT_W 28
`endif

// >>> core/sswd_sync.v
// Purpose: two-flop synchroniser for one level
// Assumes: single clock core_clk
// Notes: first stage read only by the second; rst_val is the level both stages hold in reset
`timescale 1ns/1ps
module sswd_sync (
   // clock and reset
   input wire core_clk,
   input wire rstn,
   input wire rst_val,
   // data
   input wire d,
   output reg q
);
   reg meta;
   // ==========================================
   // two stages
   always @(posedge core_clk) begin
      if (!rstn) begin
         meta <= rst_val;
         q <= rst_val;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // sswd_sync

// >>> core/sswd_top.v
// Purpose: reset generator, watchdog and power-fail flag for a host processor
// Assumes: comparator results and kick three-state detect arrive as digital levels
// Notes: long counts are parameters so simulation can shorten them
// Summary of operation
// - power_fail_flag_n low while power-fail comparator reports input below reference.
// - kick steady for watchdog timeout makes timer expire, expired flag low.
// - watchdog timer clears on reset, kick three-stated, or any kick edge.
// - floating kick keeps watchdog disabled, cleared and not counting.
// - kick transition of at least 50 ns starts fresh countdown; host kicks in time.
// - expired flag stays low until a kick edge or a floating kick clears the watchdog.
// - expired flag low while supply low, rises when supply returns unless the watchdog had already expired.
// - with kick floating, expired flag just follows supply-low indication.
// - reset output held low all the time supply-low is present.
// - reset held 200 ms after supply recovers or manual reset released.
// - any reset trigger yields a low reset pulse of nominal 200 ms.
// - brownout during a reset pulse continues it at least 140 ms.
// - active-high reset output is exact complement of active-low output.
// - watchdog expiry never resets internally; only via external manual reset link.
// - manual reset needs no debounce; long hold time absorbs bounce.
`timescale 1ns/1ps
`include "sswd_consts.vh"
module sswd_top #(
   parameter [`SSWD_CNT_W-1:0] RESET_CYC = `SSWD_RESET_CYC,
   parameter [`SSWD_CNT_W-1:0] WD_CYC = `SSWD_WD_CYC
) (
   // clock and reset
   input wire core_clk,
   input wire rstn,
   // comparator and pin indications
   input wire supply_low,
   input wire power_fail_sense,
   input wire manual_reset_n,
   input wire watchdog_kick,
   input wire kick_floating,
   // host outputs
   output reg reset_out_n,
   output reg reset_out,
   output reg watchdog_expired_n,
   output reg power_fail_flag_n
);
   localparam [1:0] ST_HOLD = 2'h0;
   localparam [1:0] ST_TIMED = 2'h1;
   localparam [1:0] ST_RUN = 2'h2;
   localparam [`SSWD_CNT_W-1:0] ONE = 28'h0000001;

   wire s_low;
   wire s_pf;
   wire s_mr_n;
   wire s_kick;
   wire s_float;
   reg [1:0] state;
   reg [`SSWD_CNT_W-1:0] rst_cnt;
   reg [`SSWD_CNT_W-1:0] wd_cnt;
   reg kick_last;
   reg kick_edge;
   reg expired;
   reg [1:0] next_state;

   // ==========================================
   // shared counter arithmetic
   // one step of a hold or watchdog counter
   function [`SSWD_CNT_W-1:0] sswd_inc;
      input [`SSWD_CNT_W-1:0] v;
      begin
         sswd_inc = v + ONE;
      end
   endfunction

   // last count of an interval of lim cycles reached
   function sswd_at_end;
      input [`SSWD_CNT_W-1:0] v;
      input [`SSWD_CNT_W-1:0] lim;
      begin
         sswd_at_end = (v >= lim - ONE);
      end
   endfunction

   // ==========================================
   // input synchronisers
   // supply low assumed during reset, so the hold starts from a trigger
   sswd_sync u_low (
      .core_clk(core_clk),
      .rstn(rstn),
      .rst_val(1'b1),
      .d(supply_low),
      .q(s_low)
   );
   // power-fail comparator level
   sswd_sync u_pf (
      .core_clk(core_clk),
      .rstn(rstn),
      .rst_val(1'b0),
      .d(power_fail_sense),
      .q(s_pf)
   );
   // manual reset idles high, no false trigger after reset
   sswd_sync u_mr (
      .core_clk(core_clk),
      .rstn(rstn),
      .rst_val(1'b1),
      .d(manual_reset_n),
      .q(s_mr_n)
   );
   // kick level for edge detect
   sswd_sync u_kick (
      .core_clk(core_clk),
      .rstn(rstn),
      .rst_val(1'b0),
      .d(watchdog_kick),
      .q(s_kick)
   );
   // three-state detect of the kick pin
   sswd_sync u_flt (
      .core_clk(core_clk),
      .rstn(rstn),
      .rst_val(1'b0),
      .d(kick_floating),
      .q(s_float)
   );

   // ==========================================
   // reset pulse sequencer
   // trigger is a held level; pulse timed from its release
   wire trigger = s_low | ~s_mr_n;

   always @* begin
      next_state = state;
      case (state)
         ST_HOLD: begin
            if (!trigger) begin
               next_state = ST_TIMED;
            end
         end
         ST_TIMED: begin
            if (trigger) begin
               next_state = ST_HOLD;
            end else if (sswd_at_end(rst_cnt, RESET_CYC)) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (trigger) begin
               next_state = ST_HOLD;
            end
         end
         default: begin
            next_state = ST_HOLD;
         end
      endcase
   end

   // hold counter restarts at each release, so a brownout mid-pulse
   // always leaves at least the full 200 ms (over the 140 ms floor)
   always @(posedge core_clk) begin
      if (!rstn) begin
         state <= ST_HOLD;
         rst_cnt <= {`SSWD_CNT_W{1'b0}};
      end else begin
         state <= next_state;
         if (state == ST_TIMED && !trigger) begin
            rst_cnt <= sswd_inc(rst_cnt);
         end else begin
            rst_cnt <= {`SSWD_CNT_W{1'b0}};
         end
      end
   end

   // ==========================================
   // watchdog timer
   // kick edges seen on synchronised level: pulses of 50 ns span many edges
   always @(posedge core_clk) begin
      if (!rstn) begin
         kick_last <= 1'b0;
         kick_edge <= 1'b0;
         wd_cnt <= {`SSWD_CNT_W{1'b0}};
         expired <= 1'b0;
      end else begin
         kick_last <= s_kick;
         kick_edge <= s_kick ^ kick_last;
         if (state != ST_RUN || s_float || kick_edge) begin
            wd_cnt <= {`SSWD_CNT_W{1'b0}};
         end else if (!sswd_at_end(wd_cnt, WD_CYC)) begin
            wd_cnt <= sswd_inc(wd_cnt);
         end
         if (s_float || kick_edge) begin
            expired <= 1'b0;
         end else if (state == ST_RUN && sswd_at_end(wd_cnt, WD_CYC)) begin
            expired <= 1'b1;
         end
      end
   end

   // ==========================================
   // registered outputs; expiry never feeds the sequencer
   // active-low reset from the sequencer's next state
   always @(posedge core_clk) begin
      if (!rstn) begin
         reset_out_n <= 1'b0;
      end else begin
         reset_out_n <= (next_state == ST_RUN);
      end
   end

   // active-high reset, same source so the pair never skews
   always @(posedge core_clk) begin
      if (!rstn) begin
         reset_out <= 1'b1;
      end else begin
         reset_out <= (next_state != ST_RUN);
      end
   end

   // expired flag, also low-supply status
   always @(posedge core_clk) begin
      if (!rstn) begin
         watchdog_expired_n <= 1'b0;
      end else begin
         watchdog_expired_n <= ~(s_low | expired);
      end
   end

   // power-fail flag follows the comparator
   always @(posedge core_clk) begin
      if (!rstn) begin
         power_fail_flag_n <= 1'b1;
      end else begin
         power_fail_flag_n <= ~s_pf;
      end
   end
endmodule // sswd_top

// >>> testbench/sswd_assertions.sv
// Purpose: port checker for sswd_top
// Assumes: one clock domain, sync reset rstn
// Notes: counters hold low time and kick idle time
`timescale 1ns/1ps
module sswd_assertions #(
   parameter [27:0] RESET_CYC = 28'h32,
   parameter [27:0] WD_CYC = 28'hC8
) (
   // clock and reset
   input wire core_clk,
   input wire rstn,
   // inputs
   input wire supply_low,
   input wire power_fail_sense,
   input wire manual_reset_n,
   input wire watchdog_kick,
   input wire kick_floating,
   // outputs
   input wire reset_out_n,
   input wire reset_out,
   input wire watchdog_expired_n,
   input wire power_fail_flag_n
);
   // ======== helpers
   logic [27:0] lowc;
   logic [27:0] idle;
   logic kp;
   // reset low time and kick idle time
   always @(posedge core_clk) begin
      kp <= watchdog_kick;
      lowc <= (!rstn || reset_out_n) ? 28'h0 : lowc + 28'h1;
      idle <= (!rstn || !reset_out_n || kick_floating || watchdog_kick != kp) ? 28'h0 : idle + 28'h1;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_quiet; (manual_reset_n && !supply_low)[*4]; endsequence
   sequence s_float; kick_floating[*6] ##0 $stable(supply_low)[*5]; endsequence
   property p_cmp; reset_out != reset_out_n; endproperty
   property p_pf; $stable(power_fail_sense)[*5] |-> power_fail_flag_n != power_fail_sense; endproperty
   property p_rst; supply_low[*5] |-> !reset_out_n; endproperty
   property p_exp; supply_low[*5] |-> !watchdog_expired_n; endproperty
   property p_hold; $rose(reset_out_n) |-> lowc >= RESET_CYC; endproperty
   property p_quiet; s_quiet ##0 reset_out_n |=> reset_out_n; endproperty
   property p_wd; idle == WD_CYC + 28'h8 |-> !watchdog_expired_n; endproperty
   property p_float; s_float |-> watchdog_expired_n != supply_low; endproperty
   a_cmp: assert property (p_cmp) else $error("reset pair");
   a_pf: assert property (p_pf) else $error("power fail flag");
   a_rst: assert property (p_rst) else $error("reset in low supply");
   a_exp: assert property (p_exp) else $error("expired in low supply");
   a_hold: assert property (p_hold) else $error("short pulse");
   a_quiet: assert property (p_quiet) else $error("reset without trigger");
   a_wd: assert property (p_wd) else $error("no expiry");
   a_float: assert property (p_float) else $error("float status");
endmodule // sswd_assertions

// >>> testbench/sswd_host.sv
// Purpose: host model that kicks the watchdog
// Assumes: en high while host software runs
// Notes: kick stays steady while en is low
`timescale 1ns/1ps
module sswd_host #(
   parameter int KP = 40
) (
   // clock and control
   input wire core_clk,
   input wire en,
   // kick line
   output logic watchdog_kick
);
   // ======== kick generator
   int cnt = 0;
   initial watchdog_kick = 1'b0;
   // toggle once per period, well inside the timeout
   always @(posedge core_clk) begin
      cnt <= (cnt >= KP - 1) ? 0 : cnt + 1;
      if (en && cnt == KP - 1) begin
         watchdog_kick <= ~watchdog_kick;
      end
   end
endmodule // sswd_host

// >>> testbench/supply_supervisor_watchdog_bench.sv
// Purpose: scenario bench for sswd_top
// Assumes: short counts 50 and 200 cycles
// Notes: inputs driven at rising edge, sampled at falling edge
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("unexpected t=%0t %h %h", $time, a, b); end end
module supply_supervisor_watchdog_bench;
   // ======== setup
   localparam [27:0] RC = 28'h32;
   localparam [27:0] WC = 28'hC8;
   logic core_clk = 1'b0, rstn = 1'b0, supply_low = 1'b0, power_fail_sense = 1'b0;
   logic manual_reset_n = 1'b1, kick_floating = 1'b0, kick_en = 1'b0;
   wire watchdog_kick, reset_out_n, reset_out, watchdog_expired_n, power_fail_flag_n;
   int error_cnt = 0, n_checks = 0, n;
   always #5 core_clk = ~core_clk;
   sswd_host #(.KP(40)) u_host (.core_clk(core_clk), .en(kick_en), .watchdog_kick(watchdog_kick));
   sswd_top #(.RESET_CYC(RC), .WD_CYC(WC)) u_dut (.core_clk(core_clk), .rstn(rstn), .supply_low(supply_low),
      .power_fail_sense(power_fail_sense), .manual_reset_n(manual_reset_n), .watchdog_kick(watchdog_kick),
      .kick_floating(kick_floating), .reset_out_n(reset_out_n), .reset_out(reset_out),
      .watchdog_expired_n(watchdog_expired_n), .power_fail_flag_n(power_fail_flag_n));
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   // count cycles until reset releases, bounded
   task automatic wait_hi();
      for (n = 0; reset_out_n !== 1'b1; n++) begin
         @(negedge core_clk);
         if (n > 2000) begin
            error_cnt++;
            final_report();
         end
      end
   endtask
   task automatic t_pf();
      @(posedge core_clk) power_fail_sense <= 1'b1;
      wt(5);
      `CHK(power_fail_flag_n, 1'b0)
      @(posedge core_clk) power_fail_sense <= 1'b0;
      wt(5);
      `CHK(power_fail_flag_n, 1'b1)
   endtask
   task automatic t_power();
      @(posedge core_clk) supply_low <= 1'b1;
      wt(6);
      `CHK({reset_out_n, reset_out, watchdog_expired_n}, 3'h2)
      @(posedge core_clk) supply_low <= 1'b0;
      wt(4);
      `CHK(watchdog_expired_n, 1'b1)
      wait_hi();
      `CHK(n >= RC - 6 && n <= RC + 4, 1'b1)
   endtask
   // bounce and brownout inside the hold
   task automatic t_mr();
      @(posedge core_clk) manual_reset_n <= 1'b0;
      wt(5);
      `CHK(reset_out_n, 1'b0)
      @(posedge core_clk) manual_reset_n <= 1'b1;
      wt(20);
      @(posedge core_clk) manual_reset_n <= 1'b0;
      @(posedge core_clk) manual_reset_n <= 1'b1;
      wt(20);
      @(posedge core_clk) supply_low <= 1'b1;
      wt(3);
      @(posedge core_clk) supply_low <= 1'b0;
      wait_hi();
      `CHK(n >= RC - 2 && n <= RC + 6, 1'b1)
   endtask
   task automatic t_wd();
      wt(WC + 12);
      `CHK({watchdog_expired_n, reset_out_n}, 2'h1)
      wt(30);
      `CHK(watchdog_expired_n, 1'b0)
      @(posedge core_clk) kick_en <= 1'b1;
      wt(50);
      `CHK(watchdog_expired_n, 1'b1)
      wt(WC * 2);
      `CHK(watchdog_expired_n, 1'b1)
      @(posedge core_clk) kick_en <= 1'b0;
   endtask
   task automatic t_float();
      @(posedge core_clk) kick_floating <= 1'b1;
      wt(WC + 20);
      `CHK(watchdog_expired_n, 1'b1)
      @(posedge core_clk) supply_low <= 1'b1;
      wt(5);
      `CHK(watchdog_expired_n, 1'b0)
      @(posedge core_clk) supply_low <= 1'b0;
      wt(5);
      `CHK(watchdog_expired_n, 1'b1)
      wait_hi();
   endtask
   initial begin
      wt(20);
      @(posedge core_clk) rstn <= 1'b1;
      wait_hi();
      t_pf();
      t_power();
      t_mr();
      t_wd();
      t_float();
      final_report();
   end
endmodule // supply_supervisor_watchdog_bench
bind sswd_top sswd_assertions #(.RESET_CYC(RESET_CYC), .WD_CYC(WD_CYC)) u_chk (.*);
